// *** pkg/umpc_consts.svh ***
`ifndef UMPC_CONSTS_SVH
`define UMPC_CONSTS_SVH
// ==========================================================================
// Register byte addresses (APB, one aligned word per register)
`define UMPC_ADDR_CTL0      12'h000
`define UMPC_ADDR_CTL1      12'h004
`define UMPC_ADDR_ADRCMP    12'h008
`define UMPC_ADDR_BRHI      12'h00C
`define UMPC_ADDR_BRLO      12'h010
`define UMPC_ADDR_RXSTAT    12'h014
`define UMPC_ADDR_TXFRAME   12'h018
// Printed shared control-1 offsets, kept as indices
`define UMPC_IDX_PORT0_CTL1 12'hF43
`define UMPC_IDX_PORT1_CTL1 12'hF4B
// ==========================================================================
// Control-1 field positions (page 000b)
`define UMPC_B_FILT1        7
`define UMPC_B_NINEBIT      6
`define UMPC_B_FILT0        5
`define UMPC_B_NINTHTX      4
`define UMPC_B_DRV_EN_POLARITY        3
`define UMPC_B_BGCTRL       2
`define UMPC_B_RDMASK       1
`define UMPC_CTL1_RESET     8'h00
`define UMPC_CTL1_WMASK     8'hFE
// Control-0 field positions
`define UMPC_B_RXEN         6
`define UMPC_B_PAREN        4
`define UMPC_PAGE_W         3
`define UMPC_B_PAGE_LO      8
`define UMPC_PAGE_MP        3'h0
`define UMPC_PAGE_DMX       3'h5
`define UMPC_CTL0_RESET     11'h000
`define UMPC_OTHER_RESET    8'h00
`define UMPC_RELOAD_RESET   16'h0000
`endif

// *** pkg/umpc_pkg.sv ***
package umpc_pkg;
  // ========================================================================
  // Received character from the serial core
  typedef struct packed {
    logic       valid;
    logic       ninth;
    logic [7:0] data;
    logic       err;
  } umpc_rxchar_s;
  // Framing settings given to the serial core
  typedef struct packed {
    logic ninebit;
    logic parity;
    logic ninthTx;
  } umpc_frame_s;
  typedef enum logic [1:0] {
    UMPC_ALL = 2'h0, UMPC_ADDR = 2'h1, UMPC_MATCH = 2'h2, UMPC_DATA = 2'h3
  } umpc_filt_e;
  typedef enum logic [2:0] {
    UMPC_IDLE = 3'b001, UMPC_SETUP = 3'b010, UMPC_ACC = 3'b100
  } umpc_bus_e;
endpackage

// *** verilog/umpc_ctl1.sv ***
`timescale 1ns/1ns
`include "umpc_consts.svh"
// Summary of operation
// - Page 000b of the shared control-1 address shows this register.
// - Nine-bit enable turns multiprocessor framing on or off.
// - Filter 00: interrupt on every received byte.
// - Filter 01: interrupt only on address bytes.
// - Filter 10: matching address and following data bytes interrupt.
// - Filter 11: only data after a matching address interrupt.
// - Nine-bit mode sends the ninth-bit value in every character.
// - Driver enable is active high at polarity 0, low at 1.
// - Receiver off, control 0: generator stopped, reads give reload.
// - Receiver off, control 1: generator counts, interrupts at zero.
// - Receiver on: control bit picks reload or live count on reads.
// - High count byte is never latched by a low byte read.
// - Data mask 0: data and errors both interrupt.
// - Data mask 1: only receiver errors interrupt.
// - Mask applies in every page except DMX, where data uses its own control.
// - Shared address routes to the register chosen by page select.
// - Nine-bit mode overrides parity enable.
// - Receive enable turns the receiver on or off.
module umpc_ctl1 #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // Serial core side
  input  wire umpc_pkg::umpc_rxchar_s rxChar,
  input  wire logic                 dmxRxIrqCtrl,
  input  wire logic                 txActive,
  output umpc_pkg::umpc_frame_s     frameCfg,
  output logic                      lineDriverEnable,
  output logic                      rxIrq,
  output logic      [7:0]           otherPageData
);
  import umpc_pkg::*;

  // ========================================================================
  // Registers
  logic [10:0] ctl0;
  logic [7:0]  ctl1;
  logic [7:0]  otherPage;
  logic [7:0]  addrCompare;
  logic [15:0] reload;
  logic [15:0] baudCount;
  logic        lastAddrMatch;
  logic        bgZeroSeen;

  // ========================================================================
  // Bus decode
  // Writes land only at the edge that completes the transfer
  wire         wrStb = psel & penable & pwrite & pready;
  wire         rdStb = psel & penable & ~pwrite;
  wire [2:0]   page  = ctl0[`UMPC_B_PAGE_LO +: `UMPC_PAGE_W];
  wire         pageMp = (page == `UMPC_PAGE_MP);
  wire         hitC0 = (paddr == `UMPC_ADDR_CTL0);
  wire         hitC1 = (paddr == `UMPC_ADDR_CTL1);
  wire         hitAc = (paddr == `UMPC_ADDR_ADRCMP);
  wire         hitHi = (paddr == `UMPC_ADDR_BRHI);
  wire         hitLo = (paddr == `UMPC_ADDR_BRLO);
  wire         hitSt = (paddr == `UMPC_ADDR_RXSTAT);
  wire         hitTf = (paddr == `UMPC_ADDR_TXFRAME);
  wire         mapped = hitC0 | hitC1 | hitAc | hitHi | hitLo | hitSt | hitTf;

  // ========================================================================
  // Control fields
  wire ninebit = ctl1[`UMPC_B_NINEBIT];
  wire drv_en_polarity   = ctl1[`UMPC_B_DRV_EN_POLARITY];
  wire bgCtrl  = ctl1[`UMPC_B_BGCTRL];
  wire rdMask  = ctl1[`UMPC_B_RDMASK];
  wire rxEn    = ctl0[`UMPC_B_RXEN];
  wire [1:0] filt = {ctl1[`UMPC_B_FILT1], ctl1[`UMPC_B_FILT0]};

  // Live count shown only when selected; no high-byte latch on low reads
  wire showLive = bgCtrl;
  wire [15:0] brView = showLive ? baudCount : reload;

  // ========================================================================
  // Receive filter
  wire isAddr  = ninebit & rxChar.ninth;
  wire isData  = ~isAddr;
  wire matchNow = (rxChar.data == addrCompare);

  function automatic logic filterPass(input logic [1:0] f,
                                      input logic a,
                                      input logic m,
                                      input logic last);
    case (f)
      UMPC_ALL:   filterPass = 1'b1;
      UMPC_ADDR:  filterPass = a;
      UMPC_MATCH: filterPass = a ? m : last;
      UMPC_DATA:  filterPass = ~a & last;
      default:    filterPass = 1'b0;
    endcase
  endfunction

  wire passFilt = ~ninebit |
                  filterPass(filt, isAddr, matchNow, lastAddrMatch);
  // DMX data interrupts follow the DMX control instead of the mask
  wire dataAllowed = (page == `UMPC_PAGE_DMX) ? dmxRxIrqCtrl
                                              : ~rdMask;
  wire rxDataEvt = rxChar.valid & ~rxChar.err & rxEn & passFilt &
                   dataAllowed & isData | rxChar.valid & ~rxChar.err &
                   rxEn & passFilt & dataAllowed & isAddr;
  wire rxErrEvt  = rxChar.valid & rxChar.err & rxEn;
  wire bgRun     = rxEn | bgCtrl;
  wire bgZero    = (baudCount == 16'h0000);
  wire timerEvt  = ~rxEn & bgCtrl & bgZero;
  wire next_irq  = rxDataEvt | rxErrEvt | timerEvt;

  // ========================================================================
  // Read mux
  wire [7:0] ctl1View = pageMp ? (ctl1 & `UMPC_CTL1_WMASK)
                               : otherPage;
  wire [31:0] next_rdata =
      hitC0 ? {21'h000000, ctl0} :
      hitC1 ? {24'h000000, ctl1View} :
      hitAc ? {24'h000000, addrCompare} :
      hitHi ? {24'h000000, brView[15:8]} :
      hitLo ? {24'h000000, brView[7:0]} :
      hitSt ? {30'h00000000, bgZeroSeen, lastAddrMatch} :
      hitTf ? {29'h00000000, frameCfg} :
      32'h00000000;

  // ========================================================================
  // Sequential logic
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl0 <= `UMPC_CTL0_RESET;
      ctl1 <= `UMPC_CTL1_RESET;
      otherPage <= `UMPC_OTHER_RESET;
      addrCompare <= 8'h00;
      reload <= `UMPC_RELOAD_RESET;
    end else if (wrStb) begin
      if (hitC0)
        ctl0 <= pwdata[10:0];
      if (hitC1 && pageMp)
        ctl1 <= pwdata[7:0] & `UMPC_CTL1_WMASK;
      if (hitC1 && !pageMp)
        otherPage <= pwdata[7:0];
      if (hitAc)
        addrCompare <= pwdata[7:0];
      if (hitHi)
        reload[15:8] <= pwdata[7:0];
      if (hitLo)
        reload[7:0] <= pwdata[7:0];
    end
  end

  // Generator: reloads at zero, held at reload when stopped
  always_ff @(posedge clk) begin
    if (srst)
      baudCount <= `UMPC_RELOAD_RESET;
    else if (!bgRun)
      baudCount <= reload;
    else if (bgZero)
      baudCount <= reload;
    else
      baudCount <= baudCount - 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (srst)
      lastAddrMatch <= 1'b0;
    else if (rxChar.valid && isAddr && rxEn)
      lastAddrMatch <= matchNow;
  end

  // Sticky zero flag; a new event wins over the read-clear
  always_ff @(posedge clk) begin
    if (srst)
      bgZeroSeen <= 1'b0;
    else if (timerEvt)
      bgZeroSeen <= 1'b1;
    // Clear at the capture edge so a later zero is never lost
    else if (rdStb && !pready && hitSt)
      bgZeroSeen <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      rxIrq <= 1'b0;
      frameCfg <= '0;
      lineDriverEnable <= 1'b0;
      otherPageData <= 8'h00;
    end else begin
      // Answer one cycle into the access phase
      pready <= psel & penable & ~pready;
      prdata <= (rdStb && !pready) ? next_rdata : prdata;
      pslverr <= psel & penable & ~pready & ~mapped;
      rxIrq <= next_irq;
      frameCfg.ninebit <= ninebit;
      frameCfg.parity <= ctl0[`UMPC_B_PAREN] & ~ninebit;
      frameCfg.ninthTx <= ninebit & ctl1[`UMPC_B_NINTHTX];
      lineDriverEnable <= txActive ^ drv_en_polarity;
      otherPageData <= otherPage;
    end
  end

  // ========================================================================
  // Checks
  a_drv_en_polarity_level: assert property (@(posedge clk) disable iff (srst)
    ##1 lineDriverEnable == ($past(txActive) ^ $past(drv_en_polarity)))
    else $error("driver enable polarity wrong");

  a_parity_override: assert property (@(posedge clk) disable iff (srst)
    ninebit |=> !frameCfg.parity)
    else $error("parity framed in nine-bit mode");

  a_ninth_gate: assert property (@(posedge clk) disable iff (srst)
    !ninebit |=> !frameCfg.ninthTx)
    else $error("ninth bit sent outside nine-bit mode");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (srst)
    !ctl1[0])
    else $error("reserved bit set");

  // A reload write needs one edge to reach the stopped counter
  a_bg_stopped: assert property (@(posedge clk) disable iff (srst)
    (!rxEn && !bgCtrl) [*2] ##0 $stable(reload) |-> baudCount == reload)
    else $error("generator not stopped");

  a_err_irq: assert property (@(posedge clk) disable iff (srst)
    rxErrEvt |=> rxIrq)
    else $error("error did not interrupt");

  a_mask_data: assert property (@(posedge clk) disable iff (srst)
    (rdMask && page != `UMPC_PAGE_DMX && !rxErrEvt && !timerEvt) |=> !rxIrq)
    else $error("masked data interrupted");

  a_filter_addr: assert property (@(posedge clk) disable iff (srst)
    (ninebit && filt == 2'h1 && rxChar.valid && !isAddr && !rxChar.err
     && !timerEvt) |=> !rxIrq)
    else $error("data byte passed address filter");

  a_timer_irq: assert property (@(posedge clk) disable iff (srst)
    timerEvt |=> rxIrq)
    else $error("timer zero did not interrupt");

  a_write_page: assert property (@(posedge clk) disable iff (srst)
    (wrStb && hitC1 && pageMp)
    |=> ctl1 == ($past(pwdata[7:0]) & `UMPC_CTL1_WMASK))
    else $error("control write lost");

  a_other_write: assert property (@(posedge clk) disable iff (srst)
    (wrStb && hitC1 && !pageMp) |=> otherPage == $past(pwdata[7:0]))
    else $error("other page write lost");

  a_other_hold: assert property (@(posedge clk) disable iff (srst)
    (wrStb && hitC1 && !pageMp) |=> ctl1 == $past(ctl1))
    else $error("control changed from other page");

  a_err_resp: assert property (@(posedge clk) disable iff (srst)
    (psel && penable && !pready && !mapped) |=> (pready && pslverr))
    else $error("unmapped access not flagged");

  a_ninebit_out: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> frameCfg.ninebit == $past(ninebit))
    else $error("framing mode not passed on");

  a_ninth_value: assert property (@(posedge clk) disable iff (srst)
    ninebit |=> frameCfg.ninthTx == $past(ctl1[`UMPC_B_NINTHTX]))
    else $error("ninth bit value wrong");

  a_all_bytes: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && !rxChar.err && rxEn && ninebit && filt == 2'h0
     && dataAllowed) |=> rxIrq)
    else $error("byte missed with open filter");

  a_addr_pass: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && !rxChar.err && rxEn && ninebit && filt == 2'h1
     && isAddr && dataAllowed) |=> rxIrq)
    else $error("address byte missed");

  a_match_addr: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && !rxChar.err && rxEn && ninebit && filt == 2'h2
     && isAddr && matchNow && dataAllowed) |=> rxIrq)
    else $error("matching address missed");

  a_match_data: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && !rxChar.err && rxEn && ninebit && filt == 2'h2
     && !isAddr && lastAddrMatch && dataAllowed) |=> rxIrq)
    else $error("data after match missed");

  a_addr_quiet: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && !rxChar.err && rxEn && ninebit && filt == 2'h3
     && isAddr) |=> !rxIrq)
    else $error("address byte interrupted");

  a_data_match: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && !rxChar.err && rxEn && ninebit && filt == 2'h3
     && !isAddr && lastAddrMatch && dataAllowed) |=> rxIrq)
    else $error("selected data missed");

  a_unmasked: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && !rxChar.err && rxEn && !ninebit && !rdMask
     && page != `UMPC_PAGE_DMX) |=> rxIrq)
    else $error("unmasked data missed");

  a_dmx_gate: assert property (@(posedge clk) disable iff (srst)
    (rxChar.valid && page == `UMPC_PAGE_DMX && !dmxRxIrqCtrl
     && !rxErrEvt && !timerEvt) |=> !rxIrq)
    else $error("data interrupted in dmx page");

  a_rx_off_quiet: assert property (@(posedge clk) disable iff (srst)
    (!rxEn && !timerEvt) |=> !rxIrq)
    else $error("interrupt with receiver off");

  // Read data is captured in the first access cycle
  a_reload_view: assert property (@(posedge clk) disable iff (srst)
    (rdStb && !pready && hitLo && !bgCtrl)
    |=> prdata == {24'h000000, $past(reload[7:0])})
    else $error("reload not shown");

  a_live_view: assert property (@(posedge clk) disable iff (srst)
    (rdStb && !pready && hitLo && bgCtrl)
    |=> prdata == {24'h000000, $past(baudCount[7:0])})
    else $error("live low byte not shown");

  a_live_high: assert property (@(posedge clk) disable iff (srst)
    (rdStb && !pready && hitHi && bgCtrl)
    |=> prdata == {24'h000000, $past(baudCount[15:8])})
    else $error("live high byte not shown");

  a_bg_count: assert property (@(posedge clk) disable iff (srst)
    (bgRun && !bgZero) |=> baudCount == $past(baudCount) - 16'h0001)
    else $error("generator did not count");

  a_zero_sticky: assert property (@(posedge clk) disable iff (srst)
    timerEvt |=> bgZeroSeen)
    else $error("zero flag not set");
endmodule

// *** sim/umpc_node_model.sv ***
`timescale 1ns/1ns
// ==========================================================
// Far node on the shared line, seen as decoded characters
module umpc_node_model (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Bench request
  input  wire logic              send,
  input  wire logic              ninth,
  input  wire logic [7:0]        data,
  input  wire logic              err,
  // To device
  output umpc_pkg::umpc_rxchar_s rxChar
);
  import umpc_pkg::*;
  // Idle ninth bit and data are inverted so a stale byte never passes for fresh
  always_ff @(posedge clk) begin
    if (srst) rxChar <= '0;
    else if (send) rxChar <= {1'b1, ninth, data, err};
    else rxChar <= {1'b0, ~rxChar.ninth, ~rxChar.data, 1'b0};
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
`include "umpc_consts.svh"
module tb;
  import umpc_pkg::*;
  logic         clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd;
  logic         pready, pslverr, lastErr, send = 0, ninth = 0, err = 0;
  logic         txActive = 0, lineDriverEnable, rxIrq, dmx = 0;
  logic [7:0]   data = '0, otherPageData;
  umpc_rxchar_s rxChar;
  umpc_frame_s  frameCfg;
  int           errors = 0, samples_checked = 0, cycles = 0, irqs = 0;
  umpc_ctl1 dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rxChar(rxChar),
    .dmxRxIrqCtrl(dmx), .txActive(txActive), .frameCfg(frameCfg),
    .lineDriverEnable(lineDriverEnable), .rxIrq(rxIrq),
    .otherPageData(otherPageData));
  umpc_node_model node (.clk(clk), .srst(srst), .send(send),
    .ninth(ninth), .data(data), .err(err), .rxChar(rxChar));
  always #10 clk = ~clk;
  // Ceiling sits far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (rxIrq === 1'b1) irqs++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  // ==========================================================
  // Shared tasks
  task stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Idle cycle at the end keeps back-to-back calls from double driving
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task send_char(input logic n, input logic [7:0] d, input logic e,
                 output int got);
    int c0;
    c0 = irqs;
    send <= 1;
    ninth <= n;
    data <= d;
    err <= e;
    @(posedge clk) send <= 0;
    repeat (4) @(posedge clk);
    got = irqs - c0;
  endtask
  // ==========================================================
  // Scenarios
  task t_regs();
    apb(0, `UMPC_ADDR_CTL1, 0); check(rd, 32'h0);
    wr(`UMPC_ADDR_CTL1, 32'hFE);
    apb(0, `UMPC_ADDR_CTL1, 0); check(rd, 32'hFE);
    apb(0, 12'h0FC, 0); check(32'(lastErr), 32'h1);
    check(rd, 32'h0);
    wr(`UMPC_ADDR_CTL0, 32'h100);
    wr(`UMPC_ADDR_CTL1, 32'h5B);
    apb(0, `UMPC_ADDR_CTL1, 0); check(rd, 32'h5B);
    check(32'(otherPageData), 32'h5B);
    wr(`UMPC_ADDR_CTL0, 32'h0);
    apb(0, `UMPC_ADDR_CTL1, 0); check(rd, 32'hFE);
    $display("test regs done");
  endtask
  task t_frame();
    txActive <= 1;
    wr(`UMPC_ADDR_CTL0, 32'h10);
    wr(`UMPC_ADDR_CTL1, 32'h58);
    repeat (2) @(posedge clk);
    check(32'(frameCfg), 32'h5);
    check(32'(lineDriverEnable), 32'h0);
    wr(`UMPC_ADDR_CTL1, 32'h0);
    repeat (2) @(posedge clk);
    check(32'(frameCfg), 32'h2);
    check(32'(lineDriverEnable), 32'h1);
    $display("test frame done");
  endtask
  task t_filter();
    logic [3:0] exp [4];
    logic [1:0] m;
    int got;
    // Events: matching address, data, other address, data
    exp = '{4'b1111, 4'b0101, 4'b0011, 4'b0010};
    wr(`UMPC_ADDR_CTL0, 32'h40);
    wr(`UMPC_ADDR_ADRCMP, 32'h33);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(`UMPC_ADDR_CTL1, {24'h0, m[1], 1'b1, m[0], 5'h0});
      for (int e = 0; e < 4; e++) begin
        send_char(e % 2 == 0, (e == 2) ? 8'h44 : 8'h33, 1'b0, got);
        check(got, 32'(exp[i][e]));
      end
    end
    wr(`UMPC_ADDR_CTL1, 32'h02);
    send_char(1'b0, 8'h12, 1'b0, got); check(got, 0);
    send_char(1'b0, 8'h12, 1'b1, got); check(got, 1);
    wr(`UMPC_ADDR_CTL1, 32'h00);
    send_char(1'b0, 8'h12, 1'b0, got); check(got, 1);
    wr(`UMPC_ADDR_CTL0, 32'h540);
    send_char(1'b0, 8'h12, 1'b0, got); check(got, 0);
    dmx <= 1;
    send_char(1'b0, 8'h12, 1'b0, got); check(got, 1);
    $display("test filter done");
  endtask
  task t_baud();
    int c0;
    logic [31:0] first;
    wr(`UMPC_ADDR_CTL0, 32'h0);
    wr(`UMPC_ADDR_BRHI, 32'h0);
    wr(`UMPC_ADDR_BRLO, 32'h20);
    c0 = irqs;
    repeat (80) @(posedge clk);
    check(irqs - c0, 0);
    apb(0, `UMPC_ADDR_BRLO, 0); check(rd, 32'h20);
    wr(`UMPC_ADDR_CTL1, 32'h04);
    c0 = irqs;
    repeat (80) @(posedge clk);
    check(32'(irqs - c0 >= 2), 1);
    apb(0, `UMPC_ADDR_RXSTAT, 0); check(32'(rd[1]), 32'h1);
    apb(0, `UMPC_ADDR_BRHI, 0); check(rd, 32'h0);
    apb(0, `UMPC_ADDR_BRLO, 0);
    first = rd;
    apb(0, `UMPC_ADDR_BRLO, 0); check(32'(rd != first), 1);
    wr(`UMPC_ADDR_CTL0, 32'h40);
    wr(`UMPC_ADDR_CTL1, 32'h0);
    apb(0, `UMPC_ADDR_BRLO, 0); check(rd, 32'h20);
    $display("test baud done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    t_regs();
    t_frame();
    t_filter();
    t_baud();
    stop_test();
  end
endmodule
